/* test_wake_source_ctrl.sv */
/* Bench for wake_source_ctrl, rows per source; assumes one-cycle answers. */
`timescale 1ns/1ns
`default_nettype none
module test_wake_source_ctrl;
   logic i_clock, i_reset, wr, rd, sl, rv, req, ch, rx, ra;
   logic [11:0] ad;
   logic [15:0] wd, rdt;
   logic [18:0] ev;
   logic [31:0] en [38], rs [38];
   int mismatches = 0, samples_checked = 0, cycles = 0, i;
   always #20 i_clock = ~i_clock;
   wake_source_ctrl wake_source_ctrl_inst (.i_clock(i_clock), .i_reset(i_reset), .i_reg_addr(ad),
      .i_reg_write(wr), .i_reg_read(rd), .i_reg_wdata(wd), .o_reg_rdata(rdt), .o_reg_rvalid(rv),
      .i_asleep(sl), .i_link_activity_wake(ev[15]), .i_system_fault_wake(ev[14]),
      .i_balance_done_wake(ev[13]), .i_wake_pin_wake(ev[12]), .i_alarm_pin_wake(ev[11]),
      .i_analog_limit_wake(ev[10:3]), .i_cell_limit_wake(ev[2:0]),
      .i_balance_protect_wake(ev[18]), .i_aux_a_undervolt_wake(ev[17]),
      .i_aux_a_overvolt_wake(ev[16]), .o_wake_request(req), .o_chain_wake_frame_send(ch),
      .o_wake_pin_rx_enable(rx), .o_wake_reason_any(ra));
   // One compare task per kind of result: read answer, wake pulses, levels
   task automatic chk_read(input logic [15:0] exp);
      samples_checked++;
      if ({rv, rdt} !== {1'b1, exp}) begin
         mismatches++;
         $display("MISMATCH %0t read valid %b data %h exp %h", $time, rv, rdt, exp);
      end
   endtask
   task automatic chk_wake(input logic [1:0] exp);
      samples_checked++;
      if ({req, ch} !== exp) begin
         mismatches++;
         $display("MISMATCH %0t wake %b%b exp %b", $time, req, ch, exp);
      end
   endtask
   task automatic chk_level(input logic [1:0] exp);
      samples_checked++;
      if ({rx, ra} !== exp) begin
         mismatches++;
         $display("MISMATCH %0t levels %b%b exp %b", $time, rx, ra, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(negedge i_clock) {wr, rd, ad, wd} = {w, !w, a, d};
      @(negedge i_clock) {wr, rd} = 2'b00;
      if (!w) chk_read(d);
   endtask
   task automatic fire(input logic [18:0] e, input logic [1:0] d);
      @(negedge i_clock) {ev, sl} = {e, 1'b1};
      @(negedge i_clock) {ev, sl} = 20'h00000;
      chk_wake(d);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Ceiling sits several times above the roughly 430 cycles the tests need
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_sim;
      end
   end
   initial begin
      {i_clock, i_reset, wr, rd, sl, ad, wd, ev} = 52'h4_0000_0000_0000;
      // Odd rows enable only the source, even rows all others; only the link needs none
      for (i = 0; i < 38; i++) begin
         rs[i] = 32'h1 << (i > 35 ? 24 : i / 2);
         en[i] = i % 2 ? rs[i] : ~rs[i];
         if (i % 2 == 0 && i != 30) rs[i] = 32'h0;
      end
      repeat (8) @(posedge i_clock);
      @(negedge i_clock) i_reset = 1'b0;
      for (i = 0; i < 38; i++) begin
         bus(1'b1, 12'h408, en[i][15:0]);
         bus(1'b1, 12'h409, en[i][31:16]);
         fire(19'h1 << (i / 2), {rs[i] != 32'h0, 1'b0});
         bus(1'b0, 12'h40A, rs[i][15:0]);
         bus(1'b0, 12'h40B, rs[i][31:16]);
      end
      bus(1'b1, 12'h409, 16'hFFFF);
      bus(1'b0, 12'h409, 16'h0103);
      bus(1'b1, 12'h40B, 16'hFFFF);
      bus(1'b0, 12'h40B, 16'h0000);
      bus(1'b0, 12'h7FF, 16'h0000);
      bus(1'b1, 12'h408, 16'h9000);
      bus(1'b0, 12'h408, 16'h9000);
      chk_level(2'b10);
      // An enabled event while awake must leave no trace
      @(negedge i_clock) ev = 19'h01000;
      @(negedge i_clock) ev = 19'h00000;
      chk_wake(2'b00);
      chk_level(2'b10);
      fire(19'h01000, 2'b11);
      chk_level(2'b11);
      bus(1'b0, 12'h40A, 16'h1000);
      chk_level(2'b10);
      fire(19'h09000, 2'b11);
      bus(1'b0, 12'h40A, 16'h9000);
      // Wake held across a reason read: the set beats the clear
      @(negedge i_clock) {ev, sl} = {19'h01000, 1'b1};
      bus(1'b0, 12'h40A, 16'h1000);
      {ev, sl} = 20'h00000;
      bus(1'b0, 12'h40A, 16'h1000);
      bus(1'b0, 12'h40A, 16'h0000);
      // Reset in mid-run clears enables and reasons alike
      fire(19'h11000, 2'b11);
      @(negedge i_clock) i_reset = 1'b1;
      repeat (2) @(negedge i_clock);
      i_reset = 1'b0;
      chk_level(2'b00);
      bus(1'b0, 12'h408, 16'h0000);
      bus(1'b0, 12'h409, 16'h0000);
      bus(1'b0, 12'h40A, 16'h0000);
      bus(1'b0, 12'h40B, 16'h0000);
      end_sim;
   end
endmodule
`default_nettype wire

/* wake_map.vh */
/*
 Constants for the wake-up source enable and reason logging block:
 register offsets, field positions, masks and reset values.
 Assumes it is included by bare name from the design file.
*/
// Overview of operation
// - Balancing protection wakes the device only if high enable bit 8 is set.
// - Aux input A undervoltage wakes only if high enable bit 1 is set.
// - Aux input A overvoltage wakes only if high enable bit 0 is set.
// - All enable bits reset to zero and are host readable and writable.
// - High registers bits 15:9 and 7:2 read zero and ignore writes.
// - Low reason bit 15 latches a communication wake; clears on read.
// - Low reason bit 14 latches a system fault wake; clears on read.
// - Low reason bit 13 latches a balancing-done wake; clears on read.
// - Low reason bit 12 latches a wake pin wake; clears on read.
// - Low reason bit 11 latches an alarm pin wake; clears on read.
// - Low reason bits 10:3 latch analog input 3..0 limit wakes; clear on read.
// - Low reason bits 2:0 latch cell undervolt 1, undervolt 0, overvolt wakes.
// - High reason bit 8 latches a balancing protection wake; clears on read.
// - High reason bits 1:0 latch aux A undervolt and overvolt wakes.
// - Reason bits are read only to the host and reset to zero.
// - Low enable bits 14:0 gate each source at its matching reason bit position.
// - Chain enable bit 15 plus a non-communication wake sends chain wake frames.
// - Wake pin enable bit turns on the wake input 0 receiver.
`ifndef WAKE_MAP_VH
`define WAKE_MAP_VH

`define WK_ADDR_W        12
`define WK_ADDR_EN_LO    12'h408
`define WK_ADDR_EN_HI    12'h409
`define WK_ADDR_RSN_LO   12'h40A
`define WK_ADDR_RSN_HI   12'h40B

`define WK_EN_HI_MASK    16'h0103
`define WK_RESET_VALUE   16'h0000

`define WK_BIT_CHAIN     15
`define WK_BIT_LINK      15
`define WK_BIT_WAKE_PIN  12
`define WK_BIT_BAL_PROT  8
`define WK_BIT_AUX_UV    1
`define WK_BIT_AUX_OV    0

`define WK_NUM_SRC       19

`endif

/* wake_source_ctrl.v */
/*
 Wake-up source gating and reason logging. Four 16-bit registers sit
 on a simple strobe port at their fixed offsets. Assumes event inputs
 are synchronous one-cycle or level indications from the detectors,
 and that i_asleep is high while the device sleeps.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wake_map.vh"

module wake_source_ctrl (
   // Clock and reset
   input  wire                    i_clock,
   input  wire                    i_reset,
   // Register port
   input  wire [`WK_ADDR_W-1:0]   i_reg_addr,
   input  wire                    i_reg_write,
   input  wire                    i_reg_read,
   input  wire [15:0]             i_reg_wdata,
   output reg  [15:0]             o_reg_rdata,
   output reg                     o_reg_rvalid,
   // Power state
   input  wire                    i_asleep,
   // Wake events from the detectors
   input  wire                    i_link_activity_wake,
   input  wire                    i_system_fault_wake,
   input  wire                    i_balance_done_wake,
   input  wire                    i_wake_pin_wake,
   input  wire                    i_alarm_pin_wake,
   input  wire [7:0]              i_analog_limit_wake,
   input  wire [2:0]              i_cell_limit_wake,
   input  wire                    i_balance_protect_wake,
   input  wire                    i_aux_a_undervolt_wake,
   input  wire                    i_aux_a_overvolt_wake,
   // Wake outputs
   output reg                     o_wake_request,
   output reg                     o_chain_wake_frame_send,
   output wire                    o_wake_pin_rx_enable,
   output wire                    o_wake_reason_any
);

   localparam NS = `WK_NUM_SRC;

   reg  [15:0]   en_lo_ff;
   reg  [15:0]   en_hi_ff;
   reg  [NS-1:0] reason_ff;

   wire          wr_en_lo  = i_reg_write & (i_reg_addr == `WK_ADDR_EN_LO);
   wire          wr_en_hi  = i_reg_write & (i_reg_addr == `WK_ADDR_EN_HI);
   wire          rd_rsn_lo = i_reg_read & (i_reg_addr == `WK_ADDR_RSN_LO);
   wire          rd_rsn_hi = i_reg_read & (i_reg_addr == `WK_ADDR_RSN_HI);

   // Source order: low reason bits 15:0, then aux OV, aux UV, balance protect
   wire [NS-1:0] src_all = {i_balance_protect_wake,
                            i_aux_a_undervolt_wake,
                            i_aux_a_overvolt_wake,
                            i_link_activity_wake,
                            i_system_fault_wake,
                            i_balance_done_wake,
                            i_wake_pin_wake,
                            i_alarm_pin_wake,
                            i_analog_limit_wake,
                            i_cell_limit_wake};

   // Communication always wakes; bit 15 of the low enable is the chain enable
   wire [NS-1:0] en_all = {en_hi_ff[`WK_BIT_BAL_PROT],
                           en_hi_ff[`WK_BIT_AUX_UV],
                           en_hi_ff[`WK_BIT_AUX_OV],
                           1'b1,
                           en_lo_ff[14:0]};

   wire [NS-1:0] trig = src_all & en_all & {NS{i_asleep}};

   wire [NS-1:0] clr_all = {{3{rd_rsn_hi}}, {16{rd_rsn_lo}}};

   wire          trig_other = |trig[NS-1:16] | (|trig[14:0]);

   // Enable registers
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         en_lo_ff <= `WK_RESET_VALUE;
         en_hi_ff <= `WK_RESET_VALUE;
      end else begin
         if (wr_en_lo) begin
            en_lo_ff <= i_reg_wdata;
         end
         if (wr_en_hi) begin
            // Reserved bits never store, so they read back zero
            en_hi_ff <= i_reg_wdata & `WK_EN_HI_MASK;
         end
      end
   end

   // One sticky reason bit per source; a new wake beats a same-cycle read clear
   genvar g;
   generate
      for (g = 0; g < NS; g = g + 1) begin : g_reason
         always @(posedge i_clock or posedge i_reset) begin
            if (i_reset) begin
               reason_ff[g] <= 1'b0;
            end else if (trig[g]) begin
               reason_ff[g] <= 1'b1;
            end else if (clr_all[g]) begin
               reason_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Register read data, valid one cycle after the read strobe
   reg [15:0] nxt_rdata;
   always @* begin
      nxt_rdata = 16'h0000;
      case (i_reg_addr)
         `WK_ADDR_EN_LO:  nxt_rdata = en_lo_ff;
         `WK_ADDR_EN_HI:  nxt_rdata = en_hi_ff;
         `WK_ADDR_RSN_LO: nxt_rdata = reason_ff[15:0];
         `WK_ADDR_RSN_HI: nxt_rdata = {7'h00, reason_ff[18],
                                       6'h00, reason_ff[17:16]};
         default:         nxt_rdata = 16'h0000;
      endcase
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_reg_rdata  <= 16'h0000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_read;
         if (i_reg_read) begin
            o_reg_rdata <= nxt_rdata;
         end
      end
   end

   // Wake pulses; chain frames only when some non-link source woke us
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_wake_request          <= 1'b0;
         o_chain_wake_frame_send <= 1'b0;
      end else begin
         o_wake_request          <= |trig;
         o_chain_wake_frame_send <= en_lo_ff[`WK_BIT_CHAIN] & trig_other;
      end
   end

   assign o_wake_pin_rx_enable = en_lo_ff[`WK_BIT_WAKE_PIN];
   assign o_wake_reason_any    = |reason_ff;

endmodule
`default_nettype wire

/* wake_source_ctrl_assertions.sv */
/* Port checker for wake_source_ctrl; assumes its one clock and async reset. */
`timescale 1ns/1ns
`default_nettype none
module wake_source_ctrl_checker (
   // Clock and reset
   input wire logic        i_clock,
   input wire logic        i_reset,
   // Register port
   input wire logic [11:0] i_reg_addr,
   input wire logic        i_reg_write,
   input wire logic        i_reg_read,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic        o_reg_rvalid,
   // Power state and link event
   input wire logic        i_asleep,
   input wire logic        i_link_activity_wake,
   // Wake outputs
   input wire logic        o_wake_request,
   input wire logic        o_chain_wake_frame_send,
   input wire logic        o_wake_pin_rx_enable,
   input wire logic        o_wake_reason_any
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   a_rd_answer: assert property (i_reg_read |=> o_reg_rvalid) else $error("no data");
   a_rd_once: assert property (!i_reg_read |=> !o_reg_rvalid) else $error("extra");
   a_rsv_zero: assert property (i_reg_read && i_reg_addr[11:2] == 10'h102
      && i_reg_addr[0] |=> (o_reg_rdata & 16'hFEFC) == 16'h0000) else $error("reserved");
   a_rx_follows: assert property (i_reg_write && i_reg_addr == 12'h408
      |=> o_wake_pin_rx_enable == $past(i_reg_wdata[12])) else $error("receiver");
   a_link_wake: assert property (i_asleep && i_link_activity_wake
      |=> o_wake_request && o_wake_reason_any) else $error("link");
   a_awake_quiet: assert property (!i_asleep |=> !o_wake_request) else $error("awake");
   a_chain_cause: assert property (o_chain_wake_frame_send |-> o_wake_request)
      else $error("chain");
   a_reason_hold: assert property (o_wake_reason_any && !i_reg_read |=> o_wake_reason_any)
      else $error("lost");
   c_chain: cover property (o_chain_wake_frame_send);
   c_rx_on: cover property (o_wake_pin_rx_enable);
   c_reason: cover property (o_reg_rvalid && o_reg_rdata != 16'h0000);
endmodule
bind wake_source_ctrl wake_source_ctrl_checker wake_source_ctrl_checker_inst (.*);
`default_nettype wire
